// ### hdl/mie_exec.sv
// Execution unit for misc, index and decimal adjust instructions
`timescale 1ns/1ns
`default_nettype none
// How it works
// - The stop release set takes port D, port C, pin and key enables from operand bits 3, 4, 5 and 7 and ignores bits 6 and 2 to 0.
// - Switching to the fast clock starts the high-speed oscillator first and moves the clock select only afterwards.
// - Switching to the slow clock moves the clock select to the crystal first and then stops the high-speed oscillator.
// - The first flag read writes port D, summary, port C and backup flags as bits 3 to 0 to the result register and the nibble.
// - The second flag read writes predivider start flag, predivider stage fifteen, timer one and pin flags as bits 3 to 0.
// - The third flag read writes counter overflow start flag, a zero, timer two and key low flags as bits 3 to 0.
// - The status read writes zero, counter overflow, watchdog enable and clock select as bits 3 to 0.
// - Each index load copies the addressed nibble into the upper, high or low nibble of the pointer.
// - The index compare sets a skip that turns the next instruction into a no-operation when the low pointer byte equals the immediate.
// - Decimal adjust after add adds six and sets carry above nine without carry, adds six and keeps carry for 0 to 3 with carry, else leaves both.
// - Decimal adjust after subtract adds hex A for 6 to F without carry, else leaves the value, and never changes carry.
// - Memory destination variants write the adjusted value to the result register and to the nibble or pointer location.
// - Auto-increment variants step the pointer by one after storing at the location it addresses.
module mie_exec
  import mie_pkg::*;
#(
  parameter int OSC_SETTLE_CYC = MIE_OSC_SETTLE_CYC
)(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  // Instruction port from the sequencer
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire mie_cmd_type   cmd,
  input  wire mie_flags_type flags,
  // Accumulator load from the arithmetic unit
  input  wire logic          acc_load,
  input  wire logic [3:0]    acc_in,
  input  wire logic          carry_in,
  output logic [3:0]         main_result_register,
  output logic               carry_flag,
  output logic [11:0]        table_index_pointer,
  output mie_mem_type        mem,
  output logic               skip_next,
  output logic [3:0]         stop_release_enables,
  output logic               high_speed_oscillator,
  output logic               clock_select_flag,
  input  wire logic          osc_ready_pin,
  // AXI4-Lite slave
  input  wire logic [3:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [3:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               irq
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [4:0] adjust(input logic sub,
                                        input logic [3:0] a,
                                        input logic c);
    logic [3:0] r;
    logic       rc;
    r  = a;
    rc = c;
    if (!sub)
    begin
      if (!c && a > MIE_BCD_MAX)
      begin
        r  = a + MIE_BCA_FIX;
        rc = 1'b1;
      end
      else if (c && a <= MIE_BCA_CARRY_MAX)
        r = a + MIE_BCA_FIX;
    end
    else if (!c && a >= MIE_BCS_MIN)
      r = a + MIE_BCS_FIX;
    return {rc, r};
  endfunction

  function automatic logic is_adjust(input mie_op_type op);
    return op >= MIE_OP_BCA;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [1:0] {
    MIE_CLK_IDLE,
    MIE_CLK_WAIT_OSC,
    MIE_CLK_STOP_OSC
  } mie_clk_state_type;

  mie_clk_state_type clk_state_reg;
  logic [15:0]       settle_cnt_reg;
  logic              osc_meta_reg;
  logic              osc_sync_reg;
  logic [0:0]        ctrl_reg;
  logic [1:0]        irq_sts_reg;
  logic [1:0]        irq_msk_reg;
  logic [1:0]        irq_event;
  logic              take;
  logic              exec;
  logic              sub_op;
  logic [4:0]        adj;
  logic [3:0]        read_val;
  logic              is_read;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [3:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wr_go;

  // ****************************************
  // Command decode
  // ****************************************
  assign cmd_ready = ctrl_reg[MIE_CTRL_ENABLE_BIT]
                     && clk_state_reg == MIE_CLK_IDLE;
  assign take   = ce && cmd_valid && cmd_ready;
  assign exec   = take && !skip_next;
  assign sub_op = cmd.op >= MIE_OP_BCS;
  assign adj    = adjust(sub_op, main_result_register, carry_flag);

  always_comb
  begin
    is_read  = 1'b1;
    read_val = 4'h0;
    case (cmd.op)
      MIE_OP_READ_FLAGS_A:
        read_val = {flags.port_d_start_flag, flags.summary_start_flag,
                    flags.port_c_start_flag, flags.backup_mode_flag};
      MIE_OP_READ_FLAGS_B:
        read_val = {flags.predivider_start_flag,
                    flags.predivider_stage_fifteen,
                    flags.timer_one_start_flag,
                    flags.pin_start_flag};
      MIE_OP_READ_FLAGS_C:
        read_val = {flags.counter_overflow_start_flag, 1'b0,
                    flags.timer_two_start_flag,
                    flags.key_low_start_flag};
      MIE_OP_READ_MISC:
        read_val = {1'b0, flags.counter_overflow_flag,
                    flags.watchdog_enable_flag, clock_select_flag};
      default:
        is_read = 1'b0;
    endcase
  end

  // ****************************************
  // Result register and carry
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_result_register <= MIE_ACC_RESET;
      carry_flag           <= 1'b0;
    end
    else if (ce)
    begin
      if (exec && is_read)
        main_result_register <= read_val;
      else if (exec && is_adjust(cmd.op))
      begin
        main_result_register <= adj[3:0];
        carry_flag           <= adj[4];
      end
      else if (acc_load)
      begin
        main_result_register <= acc_in;
        carry_flag           <= carry_in;
      end
    end
  end

  // ****************************************
  // Memory write
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mem <= '0;
    else if (ce)
    begin
      mem.mem_we   <= 1'b0;
      mem.to_index <= 1'b0;
      mem.addr     <= table_index_pointer;
      if (exec && is_read)
      begin
        mem.mem_we <= 1'b1;
        mem.data   <= read_val;
      end
      else if (exec && cmd.op inside {MIE_OP_BCA_RX, MIE_OP_BCS_RX})
      begin
        mem.mem_we <= 1'b1;
        mem.data   <= adj[3:0];
      end
      else if (exec && cmd.op inside {MIE_OP_BCA_HL, MIE_OP_BCA_HL_INC,
                                      MIE_OP_BCS_HL, MIE_OP_BCS_HL_INC})
      begin
        mem.mem_we   <= 1'b1;
        mem.to_index <= 1'b1;
        mem.data     <= adj[3:0];
      end
    end
  end

  // ****************************************
  // Table index pointer
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      table_index_pointer <= MIE_PTR_RESET;
    else if (exec)
    begin
      case (cmd.op)
        MIE_OP_LOAD_UPPER: table_index_pointer[11:8] <= cmd.rx_data;
        MIE_OP_LOAD_HIGH:  table_index_pointer[7:4]  <= cmd.rx_data;
        MIE_OP_LOAD_LOW:   table_index_pointer[3:0]  <= cmd.rx_data;
        MIE_OP_BCA_HL_INC, MIE_OP_BCS_HL_INC:
          table_index_pointer <= table_index_pointer + 12'h001;
        default:
          table_index_pointer <= table_index_pointer;
      endcase
    end
  end

  // ****************************************
  // Index compare skip
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      skip_next <= 1'b0;
    else if (take)
      skip_next <= !skip_next && cmd.op == MIE_OP_INDEX_CMP
                   && table_index_pointer[7:0] == cmd.operand;
  end

  // ****************************************
  // Stop release enables
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stop_release_enables <= MIE_SEN_RESET;
    else if (exec && cmd.op == MIE_OP_SET_STOP_REL)
      stop_release_enables <= {cmd.operand[MIE_SEN_KEY_BIT],
                               cmd.operand[MIE_SEN_PIN_BIT],
                               cmd.operand[MIE_SEN_PORT_C_BIT],
                               cmd.operand[MIE_SEN_PORT_D_BIT]};
  end

  // ****************************************
  // Oscillator ready synchroniser
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
      osc_meta_reg <= osc_ready_pin;
      osc_sync_reg <= osc_meta_reg;
    end
  end

  // ****************************************
  // Clock switch sequencer
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_state_reg         <= MIE_CLK_IDLE;
      settle_cnt_reg        <= 16'h0000;
      high_speed_oscillator <= 1'b0;
      clock_select_flag     <= 1'b0;
    end
    else if (ce)
    begin
      case (clk_state_reg)
        MIE_CLK_IDLE:
        begin
          settle_cnt_reg <= 16'h0000;
          if (exec && cmd.op == MIE_OP_CLOCK_FAST)
          begin
            high_speed_oscillator <= 1'b1;
            clk_state_reg         <= MIE_CLK_WAIT_OSC;
          end
          else if (exec && cmd.op == MIE_OP_CLOCK_SLOW)
          begin
            clock_select_flag <= 1'b0;
            clk_state_reg     <= MIE_CLK_STOP_OSC;
          end
        end
        MIE_CLK_WAIT_OSC:
        begin
          if (settle_cnt_reg < 16'(OSC_SETTLE_CYC))
            settle_cnt_reg <= settle_cnt_reg + 16'h0001;
          else if (osc_sync_reg)
          begin
            clock_select_flag <= 1'b1;
            clk_state_reg     <= MIE_CLK_IDLE;
          end
        end
        MIE_CLK_STOP_OSC:
        begin
          high_speed_oscillator <= 1'b0;
          clk_state_reg         <= MIE_CLK_IDLE;
        end
        default:
          clk_state_reg <= MIE_CLK_IDLE;
      endcase
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************
  assign irq_event[MIE_IRQ_MATCH_BIT] = take && !skip_next
    && cmd.op == MIE_OP_INDEX_CMP
    && table_index_pointer[7:0] == cmd.operand;
  assign irq_event[MIE_IRQ_CLKSW_BIT] = ce
    && ((clk_state_reg == MIE_CLK_WAIT_OSC && osc_sync_reg
         && settle_cnt_reg >= 16'(OSC_SETTLE_CYC))
        || clk_state_reg == MIE_CLK_STOP_OSC);
  assign irq = |(irq_sts_reg & irq_msk_reg);

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go         = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 4'h0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MIE_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg[1:0] == 2'h0)
                        ? MIE_RESP_OKAY : MIE_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control, mask and status registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg    <= MIE_CTRL_RESET;
      irq_msk_reg <= MIE_IRQ_RESET;
      irq_sts_reg <= MIE_IRQ_RESET;
    end
    else if (ce)
    begin
      if (wr_go && wstrb_reg[0] && awaddr_reg == MIE_CTRL_OFFSET)
        ctrl_reg <= wdata_reg[0:0];
      if (wr_go && wstrb_reg[0] && awaddr_reg == MIE_IRQ_MSK_OFFSET)
        irq_msk_reg <= wdata_reg[MIE_IRQ_WIDTH-1:0];
      if (wr_go && wstrb_reg[0] && awaddr_reg == MIE_IRQ_STS_OFFSET)
        irq_sts_reg <= (irq_sts_reg & ~wdata_reg[MIE_IRQ_WIDTH-1:0])
                       | irq_event;
      else
        irq_sts_reg <= irq_sts_reg | irq_event;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= MIE_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= MIE_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
          MIE_CTRL_OFFSET:
            s_axi_rdata[0] <= ctrl_reg[0];
          MIE_STATE_OFFSET:
          begin
            s_axi_rdata[MIE_ST_ACC_LSB+:4]   <= main_result_register;
            s_axi_rdata[MIE_ST_CARRY_BIT]    <= carry_flag;
            s_axi_rdata[MIE_ST_CLKSEL_BIT]   <= clock_select_flag;
            s_axi_rdata[MIE_ST_OSCEN_BIT]    <= high_speed_oscillator;
            s_axi_rdata[MIE_ST_SKIP_BIT]     <= skip_next;
            s_axi_rdata[MIE_ST_SEN_LSB+:4]   <= stop_release_enables;
            s_axi_rdata[MIE_ST_PTR_LSB+:12]  <= table_index_pointer;
          end
          MIE_IRQ_STS_OFFSET:
            s_axi_rdata[MIE_IRQ_WIDTH-1:0] <= irq_sts_reg;
          MIE_IRQ_MSK_OFFSET:
            s_axi_rdata[MIE_IRQ_WIDTH-1:0] <= irq_msk_reg;
          default:
            s_axi_rresp <= MIE_RESP_SLVERR;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### include/mie_pkg.sv
// Package with constants and types of the misc instruction block
package mie_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] MIE_CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] MIE_STATE_OFFSET  = 4'h4;
  localparam logic [3:0] MIE_IRQ_STS_OFFSET = 4'h8;
  localparam logic [3:0] MIE_IRQ_MSK_OFFSET = 4'hC;
  localparam logic [1:0] MIE_RESP_OKAY     = 2'h0;
  localparam logic [1:0] MIE_RESP_SLVERR   = 2'h2;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         MIE_CTRL_ENABLE_BIT = 0;
  localparam logic [0:0] MIE_CTRL_RESET      = 1'h1;
  localparam int         MIE_ST_ACC_LSB      = 0;
  localparam int         MIE_ST_CARRY_BIT    = 4;
  localparam int         MIE_ST_CLKSEL_BIT   = 5;
  localparam int         MIE_ST_OSCEN_BIT    = 6;
  localparam int         MIE_ST_SKIP_BIT     = 7;
  localparam int         MIE_ST_SEN_LSB      = 8;
  localparam int         MIE_ST_PTR_LSB      = 16;
  localparam int         MIE_IRQ_MATCH_BIT   = 0;
  localparam int         MIE_IRQ_CLKSW_BIT   = 1;
  localparam int         MIE_IRQ_WIDTH       = 2;
  localparam logic [1:0] MIE_IRQ_RESET       = 2'h0;
  localparam logic [3:0] MIE_ACC_RESET       = 4'h0;
  localparam logic [11:0] MIE_PTR_RESET      = 12'h000;
  localparam logic [3:0] MIE_SEN_RESET       = 4'h0;

  // Stop release operand bit positions
  localparam int MIE_SEN_PORT_D_BIT = 3;
  localparam int MIE_SEN_PORT_C_BIT = 4;
  localparam int MIE_SEN_PIN_BIT    = 5;
  localparam int MIE_SEN_KEY_BIT    = 7;

  // Decimal adjust limits and offsets
  localparam logic [3:0] MIE_BCD_MAX      = 4'h9;
  localparam logic [3:0] MIE_BCA_CARRY_MAX = 4'h3;
  localparam logic [3:0] MIE_BCA_FIX      = 4'h6;
  localparam logic [3:0] MIE_BCS_MIN      = 4'h6;
  localparam logic [3:0] MIE_BCS_FIX      = 4'hA;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MIE_CLK_MHZ        = 25;
  localparam int MIE_OSC_SETTLE_NS  = 400;
  localparam int MIE_OSC_SETTLE_CYC =
    (MIE_OSC_SETTLE_NS * MIE_CLK_MHZ + 999) / 1000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    MIE_OP_NONE,
    MIE_OP_SET_STOP_REL,
    MIE_OP_CLOCK_FAST,
    MIE_OP_CLOCK_SLOW,
    MIE_OP_READ_FLAGS_A,
    MIE_OP_READ_FLAGS_B,
    MIE_OP_READ_FLAGS_C,
    MIE_OP_READ_MISC,
    MIE_OP_LOAD_UPPER,
    MIE_OP_LOAD_HIGH,
    MIE_OP_LOAD_LOW,
    MIE_OP_INDEX_CMP,
    MIE_OP_BCA,
    MIE_OP_BCA_RX,
    MIE_OP_BCA_HL,
    MIE_OP_BCA_HL_INC,
    MIE_OP_BCS,
    MIE_OP_BCS_RX,
    MIE_OP_BCS_HL,
    MIE_OP_BCS_HL_INC
  } mie_op_type;

  typedef struct packed {
    mie_op_type  op;
    logic [7:0]  operand;
    logic [3:0]  rx_data;
  } mie_cmd_type;

  typedef struct packed {
    logic        port_d_start_flag;
    logic        summary_start_flag;
    logic        port_c_start_flag;
    logic        backup_mode_flag;
    logic        predivider_start_flag;
    logic        predivider_stage_fifteen;
    logic        timer_one_start_flag;
    logic        pin_start_flag;
    logic        counter_overflow_start_flag;
    logic        timer_two_start_flag;
    logic        key_low_start_flag;
    logic        counter_overflow_flag;
    logic        watchdog_enable_flag;
  } mie_flags_type;

  typedef struct packed {
    logic        mem_we;
    logic        to_index;
    logic [11:0] addr;
    logic [3:0]  data;
  } mie_mem_type;

endpackage

// ### testbench/mie_exec_checker.sv
// Checker for the misc instruction execution unit
`timescale 1ns/1ns
`default_nettype none
module mie_exec_checker
  import mie_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire mie_cmd_type cmd,
  input wire logic [3:0]  main_result_register,
  input wire logic        carry_flag,
  input wire logic [11:0] table_index_pointer,
  input wire mie_mem_type mem,
  input wire logic        skip_next,
  input wire logic [3:0]  stop_release_enables,
  input wire logic        high_speed_oscillator,
  input wire logic        clock_select_flag
);
  wire logic go;
  wire logic run;
  assign go = ce && cmd_valid && cmd_ready;
  assign run = go && !skip_next;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_stop_enables:
    assert property (run && cmd.op == MIE_OP_SET_STOP_REL |=>
      stop_release_enables == {$past(cmd.operand[7]),
      $past(cmd.operand[5:3])})
    else $error("stop enables wrong");
  a_flag_store:
    assert property (run && cmd.op == MIE_OP_READ_FLAGS_A |=> mem.mem_we
      && !mem.to_index && mem.data == main_result_register)
    else $error("flag store wrong");
  a_index_load:
    assert property (run && cmd.op == MIE_OP_LOAD_LOW |=>
      table_index_pointer[3:0] == $past(cmd.rx_data))
    else $error("low load wrong");
  a_compare_hit:
    assert property (run && cmd.op == MIE_OP_INDEX_CMP &&
      table_index_pointer[7:0] == cmd.operand |=> skip_next)
    else $error("no skip");
  a_skip_consume:
    assert property (go && skip_next |=> !skip_next && !mem.mem_we)
    else $error("skipped op acted");
  a_fast_order:
    assert property ($rose(clock_select_flag) |->
      $past(high_speed_oscillator))
    else $error("fast order wrong");
  a_slow_order:
    assert property ($fell(high_speed_oscillator) |->
      !clock_select_flag && !$past(clock_select_flag))
    else $error("slow order wrong");
  a_add_adjust:
    assert property (run && cmd.op == MIE_OP_BCA && !carry_flag &&
      main_result_register > 4'h9 |=> carry_flag &&
      main_result_register == $past(main_result_register) + 4'h6)
    else $error("add adjust wrong");
  a_sub_adjust:
    assert property (run && cmd.op == MIE_OP_BCS && !carry_flag &&
      main_result_register >= 4'h6 |=> !carry_flag &&
      main_result_register == $past(main_result_register) + 4'hA)
    else $error("sub adjust wrong");
  a_ptr_step:
    assert property (run && cmd.op == MIE_OP_BCA_HL_INC |=>
      mem.addr == $past(table_index_pointer) &&
      mem.data == main_result_register &&
      table_index_pointer == $past(table_index_pointer) + 12'h001)
    else $error("pointer step wrong");
  c_skip: cover property (run && cmd.op == MIE_OP_INDEX_CMP ##1 skip_next);
  c_fast: cover property ($rose(clock_select_flag));
  c_inc: cover property (run && cmd.op == MIE_OP_BCS_HL_INC);
endmodule
bind mie_exec mie_exec_checker i_chk (
  .aclk, .aresetn, .ce, .cmd_valid, .cmd_ready, .cmd,
  .main_result_register, .carry_flag, .table_index_pointer, .mem,
  .skip_next, .stop_release_enables, .high_speed_oscillator,
  .clock_select_flag
);
`default_nettype wire

// ### testbench/tb.sv
// Testbench for the misc instruction execution unit
`timescale 1ns/1ns
`default_nettype none
module tb
  import mie_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, osc_ready_pin = 1'b1;
  logic cmd_valid = 1'b0, acc_load = 1'b0, carry_in = 1'b0;
  logic [3:0] acc_in = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  mie_cmd_type cmd = '0;
  mie_flags_type flags = '0;
  logic cmd_ready, carry_flag, skip_next, irq;
  logic high_speed_oscillator, clock_select_flag;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [3:0] main_result_register, stop_release_enables;
  logic [11:0] table_index_pointer;
  mie_mem_type mem;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int fail_count = 0, check_count = 0, cyc = 0;
  mie_op_type ops [9] = '{MIE_OP_BCA, MIE_OP_BCA_RX, MIE_OP_BCA_HL,
    MIE_OP_BCA_HL_INC, MIE_OP_BCA_HL_INC, MIE_OP_BCS, MIE_OP_BCS_RX,
    MIE_OP_BCS_HL, MIE_OP_BCS_HL_INC};
  logic [15:0] tv [9] = '{16'h9090, 16'hA001, 16'hF051, 16'h3191,
    16'h0161, 16'h9191, 16'h6000, 16'hF090, 16'h8020};
  mie_exec #(.OSC_SETTLE_CYC(2)) i_dut (.*);
  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic exec(mie_op_type op, logic [7:0] x, logic [3:0] rx);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd <= '{op, x, rx};
    do @(negedge aclk); while (cmd_ready !== 1'b1);
    @(posedge aclk);
    cmd_valid <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic ld(logic [3:0] a, logic c);
    @(posedge aclk);
    {acc_load, acc_in, carry_in} <= {1'b1, a, c};
    @(posedge aclk);
    acc_load <= 1'b0;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, MIE_RESP_OKAY);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask
  task automatic fr(mie_op_type op, logic [3:0] e);
    exec(op, 8'h00, 4'h0);
    chk(main_result_register, e);
    chk({mem.mem_we, mem.to_index, mem.data}, {2'b10, e});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [12:0] fv;
    logic [11:0] p;
    logic hl, wm;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(MIE_CTRL_OFFSET, 32'h1, MIE_RESP_OKAY);
    rd(MIE_STATE_OFFSET, 32'h0, MIE_RESP_OKAY);
    rd(MIE_IRQ_MSK_OFFSET, 32'h0, MIE_RESP_OKAY);
    rd(4'h2, 32'h0, MIE_RESP_SLVERR);
    wr(MIE_CTRL_OFFSET, 32'h0);
    chk(cmd_ready, 1'b0);
    wr(MIE_CTRL_OFFSET, 32'h1);
    exec(MIE_OP_SET_STOP_REL, 8'hB8, 4'h0);
    chk(stop_release_enables, 4'hF);
    exec(MIE_OP_SET_STOP_REL, 8'h17, 4'h0);
    rd(MIE_STATE_OFFSET, 32'h200, MIE_RESP_OKAY);
    wr(MIE_IRQ_MSK_OFFSET, 32'h2);
    exec(MIE_OP_CLOCK_FAST, 8'h00, 4'h0);
    chk({high_speed_oscillator, clock_select_flag, cmd_ready}, 3'h4);
    while (cmd_ready !== 1'b1) @(negedge aclk);
    chk({high_speed_oscillator, clock_select_flag}, 2'h3);
    rd(MIE_IRQ_STS_OFFSET, 32'h2, MIE_RESP_OKAY);
    chk(irq, 1'b1);
    wr(MIE_IRQ_MSK_OFFSET, 32'h0);
    chk(irq, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      fv = i ? 13'h0AAA : 13'h1555;
      @(posedge aclk);
      flags <= fv;
      fr(MIE_OP_READ_FLAGS_A, fv[12:9]);
      fr(MIE_OP_READ_FLAGS_B, fv[8:5]);
      fr(MIE_OP_READ_FLAGS_C, {fv[4], 1'b0, fv[3:2]});
      fr(MIE_OP_READ_MISC, {1'b0, fv[1:0], 1'b1});
    end
    exec(MIE_OP_CLOCK_SLOW, 8'h00, 4'h0);
    chk({high_speed_oscillator, clock_select_flag}, 2'h2);
    @(negedge aclk);
    chk({high_speed_oscillator, clock_select_flag}, 2'h0);
    fr(MIE_OP_READ_MISC, {1'b0, fv[1:0], 1'b0});
    exec(MIE_OP_LOAD_UPPER, 8'h00, 4'hA);
    exec(MIE_OP_LOAD_HIGH, 8'h00, 4'h5);
    exec(MIE_OP_LOAD_LOW, 8'h00, 4'hC);
    chk(table_index_pointer, 12'hA5C);
    wr(MIE_IRQ_STS_OFFSET, 32'h3);
    wr(MIE_IRQ_MSK_OFFSET, 32'h3);
    exec(MIE_OP_INDEX_CMP, 8'h5C, 4'h0);
    chk(skip_next, 1'b1);
    exec(MIE_OP_LOAD_LOW, 8'h00, 4'h3);
    chk({skip_next, irq, table_index_pointer}, 14'h1A5C);
    wr(MIE_IRQ_STS_OFFSET, 32'h3);
    chk(irq, 1'b0);
    exec(MIE_OP_INDEX_CMP, 8'h5D, 4'h0);
    chk(skip_next, 1'b0);
    exec(MIE_OP_LOAD_LOW, 8'h00, 4'h3);
    chk(table_index_pointer, 12'hA53);
    exec(MIE_OP_LOAD_UPPER, 8'h00, 4'hF);
    exec(MIE_OP_LOAD_HIGH, 8'h00, 4'hF);
    exec(MIE_OP_LOAD_LOW, 8'h00, 4'hE);
    p = 12'hFFE;
    foreach (ops[i])
    begin
      ld(tv[i][15:12], tv[i][8]);
      hl = ops[i][1];
      wm = ops[i][1:0] != 2'h0;
      exec(ops[i], 8'h00, 4'h0);
      chk({carry_flag, main_result_register}, {tv[i][0], tv[i][7:4]});
      chk(mem.mem_we, wm);
      if (wm) chk({mem.to_index, mem.data}, {hl, tv[i][7:4]});
      if (hl) chk(mem.addr, p);
      if (&ops[i][1:0]) p++;
      chk(table_index_pointer, p);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
